// ===== verilog/io_port_pkg.sv
// Constants and types shared by the digital I/O port controller
package io_port_pkg;

  // ==========================================================
  // Geometry and timing
  localparam int NUM_PORTS = 3;
  localparam int CLK_PERIOD_NS = 25;
  localparam int PULSE_STEP_MS = 20;
  localparam int NS_PER_MS = 1000000;
  localparam int PULSE_STEP_CYCLES = PULSE_STEP_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int PULSE_CNT_W = 16;
  localparam logic [15:0] PULSE_DEFAULT = 16'h0019;

  // ==========================================================
  // Register byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_RESP = 8'h04;
  localparam logic [7:0] ADDR_MODE = 8'h08;
  localparam logic [7:0] ADDR_STATE = 8'h0C;

  // ==========================================================
  // Command word fields
  localparam int CMD_PORT_LSB = 0;
  localparam int CMD_KIND_BIT = 2;
  localparam int CMD_CODE_LSB = 3;
  localparam int CMD_CNT_LSB = 16;

  // Response word fields
  localparam int RESP_PORT_LSB = 0;
  localparam int RESP_STATE_BIT = 2;
  localparam int RESP_VALID_BIT = 3;
  localparam int RESP_ERR_BIT = 4;

  // State word fields
  localparam int STATE_LSB = 0;
  localparam int PULSE_ACT_LSB = 4;

  // ==========================================================
  // Encodings
  typedef enum logic [1:0] {
    MODE_IN = 2'h0,
    MODE_OUT = 2'h1,
    MODE_IN_PU = 2'h2,
    MODE_OUT_PU = 2'h3
  } io_mode_t;

  typedef enum logic [1:0] {
    FN_OFF = 2'h0,
    FN_ON = 2'h1,
    FN_TOGGLE = 2'h2,
    FN_PULSE = 2'h3
  } io_fn_t;

endpackage

// ===== verilog/pulse_timer.sv
// Per-port pulse timer counting 20 ms step ticks
`timescale 1ns/1ps
`default_nettype none

module pulse_timer #(
  parameter int CNT_W = io_port_pkg::PULSE_CNT_W
) (
  input wire logic clk,               // System clock
  input wire logic rst_n,             // Synchronous reset, active low
  input wire logic tick,              // One pulse per 20 ms step
  input wire logic start,             // Begin or restart a pulse
  input wire logic stop,              // Abort a running pulse
  input wire logic [CNT_W-1:0] count, // Steps, zero selects default
  output logic active,                // Pulse running
  output logic done                   // Pulse interval expired
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic act;
    logic done;
  } tmr_t;

  tmr_t r;
  tmr_t n;

  always_comb
  begin
    n = r;
    n.done = 1'b0;
    if (stop)
    begin
      n.act = 1'b0;
    end
    else if (start)
    begin
      n.act = 1'b1;
      n.cnt = (count == '0) ? CNT_W'(io_port_pkg::PULSE_DEFAULT) : count;
    end
    else if (r.act && tick)
    begin
      n.cnt = r.cnt - 1'b1;
      if (r.cnt == CNT_W'(1))
      begin
        n.act = 1'b0;
        n.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign active = r.act;
  assign done = r.done;

endmodule

`default_nettype wire

// ===== verilog/io_port_ctrl.sv
// Digital I/O port controller with APB register access
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module io_port_ctrl #(
  parameter int NUM_PORTS = io_port_pkg::NUM_PORTS,
  parameter int TICK_CYCLES = io_port_pkg::PULSE_STEP_CYCLES,
  parameter int CNT_W = io_port_pkg::PULSE_CNT_W
) (
  input wire logic CLK,                    // 40 MHz clock
  input wire logic RST_N,                  // Synchronous reset, active low
  input wire logic PSEL,                   // APB select
  input wire logic PENABLE,                // APB enable
  input wire logic PWRITE,                 // APB direction, high is write
  input wire logic [7:0] PADDR,            // APB byte address
  input wire logic [31:0] PWDATA,          // APB write data
  output logic [31:0] PRDATA,              // APB read data
  output logic PREADY,                     // APB ready
  output logic PSLVERR,                    // APB error, unmapped address
  input wire logic [NUM_PORTS-1:0] IO_IN,  // Port pin levels
  output logic [NUM_PORTS-1:0] IO_OUT,     // Port drive levels
  output logic [NUM_PORTS-1:0] IO_OE_N,    // Port drive enable, active low
  output logic [NUM_PORTS-1:0] PULLUP_EN   // Pull-up resistor enable
);

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [NUM_PORTS-1:0][1:0] mode;
    logic [NUM_PORTS-1:0] state;
    logic [NUM_PORTS-1:0] saved;
    logic [NUM_PORTS-1:0] oe_n;
    logic [NUM_PORTS-1:0] pull;
    logic [1:0] resp_port;
    logic resp_state;
    logic resp_valid;
    logic resp_err;
    logic [31:0] prdata;
    logic [TW-1:0] tick_cnt;
  } ctrl_t;

  ctrl_t r;
  ctrl_t n;

  // Reset leaves every pin undriven and without pull-up
  localparam ctrl_t CTRL_RST = '{oe_n: '1, default: '0};
  localparam logic [1:0] PORT_NONE = 2'h0;

  logic tick;
  logic [NUM_PORTS-1:0] p_start;
  logic [NUM_PORTS-1:0] p_stop;
  logic [NUM_PORTS-1:0] p_active;
  logic [NUM_PORTS-1:0] p_done;
  logic [NUM_PORTS-1:0] is_out;
  logic [NUM_PORTS-1:0] view_state;
  logic cmd_wr;
  logic mapped;
  logic [1:0] cmd_port;
  logic cmd_is_mode;
  logic [1:0] cmd_code;
  logic [CNT_W-1:0] cmd_cnt;
  logic [NUM_PORTS-1:0] port_hit;
  logic port_none;
  logic to_input;
  logic [31:0] rd_word;

  // ==========================================================
  // Command word decode
  assign cmd_wr = PSEL && PENABLE && PWRITE
    && (PADDR == io_port_pkg::ADDR_CMD);
  assign cmd_port = PWDATA[io_port_pkg::CMD_PORT_LSB +: 2];
  assign cmd_is_mode = PWDATA[io_port_pkg::CMD_KIND_BIT];
  assign cmd_code = PWDATA[io_port_pkg::CMD_CODE_LSB +: 2];
  assign cmd_cnt = PWDATA[io_port_pkg::CMD_CNT_LSB +: CNT_W];
  assign tick = (r.tick_cnt == TICK_LAST);
  assign port_none = (cmd_port == PORT_NONE);
  assign to_input = (cmd_code == io_port_pkg::MODE_IN)
    || (cmd_code == io_port_pkg::MODE_IN_PU);

  assign mapped = (PADDR == io_port_pkg::ADDR_CMD)
    || (PADDR == io_port_pkg::ADDR_RESP)
    || (PADDR == io_port_pkg::ADDR_MODE)
    || (PADDR == io_port_pkg::ADDR_STATE);

  // ==========================================================
  // Per-port pulse timers and pin views
  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++)
    begin : g_port
      assign is_out[g] = (r.mode[g] == io_port_pkg::MODE_OUT)
        || (r.mode[g] == io_port_pkg::MODE_OUT_PU);
      assign view_state[g] = is_out[g] ? r.state[g] : IO_IN[g];
      assign IO_OUT[g] = r.state[g];
      assign IO_OE_N[g] = r.oe_n[g];
      assign PULLUP_EN[g] = r.pull[g];

      // Command addressed to this port
      assign port_hit[g] = cmd_wr && (cmd_port == 2'(g + 1));

      pulse_timer #(
        .CNT_W(CNT_W)
      ) u_timer (
        .clk(CLK),
        .rst_n(RST_N),
        .tick(tick),
        .start(p_start[g]),
        .stop(p_stop[g]),
        .count(cmd_cnt),
        .active(p_active[g]),
        .done(p_done[g])
      );
    end
  endgenerate

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    n = r;
    p_start = '0;
    p_stop = '0;
    n.tick_cnt = tick ? '0 : TW'(r.tick_cnt + 1'b1);

    // Expired pulse puts back the earlier level
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      if (p_done[i])
      begin
        n.state[i] = r.saved[i];
      end
    end

    if (cmd_wr)
    begin
      n.resp_valid = 1'b1;
      n.resp_err = 1'b0;
      n.resp_port = cmd_port;
      if (port_none)
      begin
        n.resp_err = 1'b1;
      end
      for (int i = 0; i < NUM_PORTS; i++)
      begin
        if (port_hit[i])
        begin
          if (cmd_is_mode)
          begin
            n.mode[i] = cmd_code;
            if (to_input)
            begin
              p_stop[i] = 1'b1;
            end
            n.resp_state = n.state[i];
          end
          else if (!is_out[i])
          begin
            n.resp_err = 1'b1;
            n.resp_state = r.state[i];
          end
          else
          begin
            case (cmd_code)
              io_port_pkg::FN_OFF:
              begin
                n.state[i] = 1'b0;
                p_stop[i] = 1'b1;
              end
              io_port_pkg::FN_ON:
              begin
                n.state[i] = 1'b1;
                p_stop[i] = 1'b1;
              end
              io_port_pkg::FN_TOGGLE:
              begin
                n.state[i] = ~r.state[i];
                p_stop[i] = 1'b1;
              end
              io_port_pkg::FN_PULSE:
              begin
                // Restart keeps the level from before the first pulse
                if (!p_active[i])
                begin
                  n.saved[i] = r.state[i];
                  n.state[i] = ~r.state[i];
                end
                else
                begin
                  n.saved[i] = r.saved[i];
                  n.state[i] = r.state[i];
                end
                p_start[i] = 1'b1;
              end
              default:
              begin
                n.state[i] = r.state[i];
              end
            endcase
            n.resp_state = n.state[i];
          end
        end
      end
    end

    // Drive enable and pull-up registered from the next mode
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      n.oe_n[i] = !((n.mode[i] == io_port_pkg::MODE_OUT)
        || (n.mode[i] == io_port_pkg::MODE_OUT_PU));
      n.pull[i] = (n.mode[i] == io_port_pkg::MODE_IN_PU)
        || (n.mode[i] == io_port_pkg::MODE_OUT_PU);
    end

    // Read data captured in the setup cycle
    if (PSEL && !PENABLE && !PWRITE)
    begin
      n.prdata = rd_word;
    end
  end

  // ==========================================================
  // Register read view
  always_comb
  begin
    rd_word = '0;
    case (PADDR)
      io_port_pkg::ADDR_RESP:
      begin
        rd_word[io_port_pkg::RESP_PORT_LSB +: 2] = r.resp_port;
        rd_word[io_port_pkg::RESP_STATE_BIT] = r.resp_state;
        rd_word[io_port_pkg::RESP_VALID_BIT] = r.resp_valid;
        rd_word[io_port_pkg::RESP_ERR_BIT] = r.resp_err;
      end
      io_port_pkg::ADDR_MODE:
      begin
        rd_word[2*NUM_PORTS-1:0] = r.mode;
      end
      io_port_pkg::ADDR_STATE:
      begin
        rd_word[io_port_pkg::STATE_LSB +: NUM_PORTS] = view_state;
        rd_word[io_port_pkg::PULSE_ACT_LSB +: NUM_PORTS] = p_active;
      end
      default:
      begin
        rd_word = '0;
      end
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      r <= CTRL_RST;
    end
    else
    begin
      r <= n;
    end
  end

  // ==========================================================
  // APB answer, zero wait states
  assign PRDATA = r.prdata;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

endmodule

`default_nettype wire

// ===== verilog/io_port_ctrl_dummy_guard.sv
// Empty source file, holds no design unit
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== tb/io_pin_model.sv
// Pin model for the three digital I/O lines
`timescale 1ns/1ps
`default_nettype none
module io_pin_model (
  input wire logic CLK, // Clock
  input wire logic [2:0] IO_OUT, // Drive level
  input wire logic [2:0] IO_OE_N, // Drive enable
  input wire logic [2:0] PULLUP_EN, // Pull-up on
  output logic [2:0] IO_IN // Pin level
);
  // ====
  // Undriven lines without pull-up wander
  logic flt_r = 1'b0;
  always @(posedge CLK)
    flt_r <= !flt_r;
  always_comb
    for (int i = 0; i < 3; i++)
      IO_IN[i] = !IO_OE_N[i] ? IO_OUT[i] : PULLUP_EN[i] | flt_r;
endmodule
`default_nettype wire

// ===== tb/io_port_monitor.sv
// Checker for the I/O port controller
`timescale 1ns/1ps
`default_nettype none
module io_port_monitor #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic CLK, // Clock
  input wire logic RST_N, // Reset
  input wire logic PSEL, // Select
  input wire logic PENABLE, // Enable
  input wire logic PWRITE, // Direction
  input wire logic [7:0] PADDR, // Address
  input wire logic [31:0] PWDATA, // Write data
  input wire logic [2:0] IO_OUT, // Drive
  input wire logic [2:0] IO_OE_N, // Enable
  input wire logic [2:0] PULLUP_EN // Pull-up
);
  // ====
  // Command decode
  localparam int L3_LO = 2 * TICK_CYCLES;
  localparam int L3_HI = 3 * TICK_CYCLES + 2;
  localparam int D_LO = 24 * TICK_CYCLES;
  localparam int D_HI = 25 * TICK_CYCLES + 2;
  logic wr;
  logic st;
  logic [1:0] pt;
  logic [1:0] cd;
  assign wr = PSEL && PENABLE && PWRITE && PADDR == 8'h00;
  assign st = wr && !PWDATA[2];
  assign pt = PWDATA[1:0];
  assign cd = PWDATA[4:3];
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  sequence pulse_go(logic [15:0] c);
    st && pt == 2'h2 && cd == 2'h3 && !IO_OE_N[1] && PWDATA[31:16] == c;
  endsequence
  sequence flips;
    ##1 $changed(IO_OUT[1]);
  endsequence
  // ====
  // Assertions
  mode_set_a: assert property (
    wr && PWDATA[2] && pt == 2'h1 |=>
    IO_OE_N[0] == !$past(cd[0]) && PULLUP_EN[0] == $past(cd[1]))
    else $error("Mode not applied");
  on_off_a: assert property (
    st && pt == 2'h1 && !cd[1] && !IO_OE_N[0] |=> IO_OUT[0] == $past(cd[0]))
    else $error("Level not set");
  toggle_inv_a: assert property (
    st && pt == 2'h1 && cd == 2'h2 && !IO_OE_N[0] |=>
    IO_OUT[0] != $past(IO_OUT[0]))
    else $error("Toggle missed");
  input_refuse_a: assert property (
    st && pt == 2'h3 && IO_OE_N[2] |=> $stable(IO_OUT[2]))
    else $error("Input port changed");
  port_zero_a: assert property (
    wr && pt == 2'h0 |=> $stable({IO_OUT, IO_OE_N, PULLUP_EN}))
    else $error("Port zero acted");
  pulse_len_a: assert property (
    pulse_go(16'h0003) |-> flips ##[L3_LO:L3_HI] $changed(IO_OUT[1]))
    else $error("Pulse length wrong");
  pulse_def_a: assert property (
    pulse_go(16'h0000) |-> flips ##[D_LO:D_HI] $changed(IO_OUT[1]))
    else $error("Default pulse wrong");
  reset_state_a: assert property (
    $rose(RST_N) |-> IO_OE_N == 3'h7 && PULLUP_EN == 3'h0 && IO_OUT == 3'h0)
    else $error("Reset state wrong");
endmodule
bind io_port_ctrl io_port_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon_u (
  .CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
  .IO_OUT, .IO_OE_N, .PULLUP_EN);
`default_nettype wire

// ===== tb/tb_digital_io_port_control.sv
// Self-checking bench for the I/O port controller
`timescale 1ns/1ps
`default_nettype none
module tb_digital_io_port_control;
  // ====
  // Signals and instances
  typedef struct packed {
    logic [31:0] cmd;
    logic [8:0] pins;
    logic [4:0] rsp;
    logic [4:0] msk;
  } row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] io_in;
  logic [2:0] io_out;
  logic [2:0] oe_n;
  logic [2:0] pu;
  logic [31:0] rd;
  logic er;
  int err_count = 0;
  int checked = 0;
  int n;
  row_t rows [10] = '{
    '{32'h0D, 9'h180, 5'h09, 5'h1F}, '{32'h1E, 9'h110, 5'h0A, 5'h1F},
    '{32'h17, 9'h130, 5'h0B, 5'h1B}, '{32'h09, 9'h131, 5'h0D, 5'h1F},
    '{32'h12, 9'h133, 5'h0E, 5'h1F}, '{32'h11, 9'h132, 5'h09, 5'h1F},
    '{32'h02, 9'h130, 5'h0A, 5'h1F}, '{32'h0B, 9'h130, 5'h1B, 5'h1B},
    '{32'h08, 9'h130, 5'h18, 5'h18}, '{32'h05, 9'h170, 5'h09, 5'h1B}};
  always #12.5 clk = !clk;
  io_port_ctrl #(.TICK_CYCLES(4)) dut_u (.CLK(clk), .RST_N(rst_n),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IO_IN(io_in), .IO_OUT(io_out),
    .IO_OE_N(oe_n), .PULLUP_EN(pu));
  io_pin_model pin_u (.CLK(clk), .IO_OUT(io_out), .IO_OE_N(oe_n),
    .PULLUP_EN(pu), .IO_IN(io_in));
  // ====
  // Tasks
  task automatic print_verdict();
    $display("Checks %0d, errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rng(input int v, input int lo, input int hi);
    checked++;
    if (v < lo || v > hi)
    begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h..%h", $time, v, lo, hi);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (i = 0; i == 0 || (pready !== 1'b1 && i < 8); i++)
      @(posedge clk);
    if (pready !== 1'b1)
    begin
      err_count++;
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic pulse_len(input logic [31:0] cmd, input int lim);
    apb(1'b1, 8'h00, cmd);
    step(1);
    cmp(io_out[1], 1'b1);
    for (n = 0; io_out[1] !== 1'b0 && n < lim; n++)
      step(1);
    if (n >= lim)
    begin
      err_count++;
      print_verdict();
    end
  endtask
  // ====
  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    step(1);
    cmp({oe_n, pu, io_out}, 9'h1C0);
    foreach (rows[k])
    begin
      apb(1'b1, 8'h00, rows[k].cmd);
      step(1);
      cmp({oe_n, pu, io_out}, rows[k].pins);
      apb(1'b0, 8'h04, 32'h0);
      cmp(rd & rows[k].msk, rows[k].rsp & rows[k].msk);
    end
    apb(1'b0, 8'h08, 32'h0);
    cmp(rd, 32'h2C);
    apb(1'b0, 8'h10, 32'h0);
    cmp({er, rd}, 33'h100000000);
    pulse_len(32'h0003001A, 40);
    rng(n, 9, 15);
    pulse_len(32'h0000001A, 200);
    rng(n, 97, 104);
    apb(1'b1, 8'h00, 32'h0005001A);
    step(3);
    apb(1'b1, 8'h00, 32'h0A);
    step(40);
    cmp(io_out, 32'h2);
    apb(1'b1, 8'h00, 32'hFFFF001A);
    step(150);
    apb(1'b0, 8'h0C, 32'h0);
    cmp({io_out, rd[6:4], rd[2:1]}, 32'h00A);
    apb(1'b1, 8'h00, 32'h0D);
    rst_n <= 1'b0;
    step(5);
    cmp({oe_n, pu, io_out}, 9'h1C0);
    @(posedge clk);
    rst_n <= 1'b1;
    step(1);
    apb(1'b0, 8'h04, 32'h0);
    cmp({oe_n, pu, io_out, rd}, 41'h1C000000000);
    print_verdict();
  end
endmodule
`default_nettype wire
